// *** core/ecl_loader.v ***
// Contract
// RQ1 - Flags word 1 bit 7 drives the sleep and L1 suspend enable.
// RQ2 - Flags word 1 bits 6, 5:3, 2:1, 0 feed the PHY interface control.
// RQ3 - In compliance mode the link state machine picks the de-emphasis sent out.
// RQ4 - Loaded elasticity buffer mode never reaches the PHY.
// RQ5 - Flags word 2 bits 15 and 14 give overlap check and U2 exit select.
// RQ6 - Flags word 2 bits 11, 10, 9 give the green Ethernet MAC enables.
// RQ7 - Word 2 bit 12 speedup; bits 13, 8, 7:6 feed MAC control.
// RQ8 - Word 2 bits 31:24, 20:16, 5:3, 2:0 give timeouts and calibrations.
// RQ9 - Flags word 3 halves give the two detach times.
// RQ10 - GPIO word gives enable, buffer, direction and data for twelve pins.
// RQ11 - Byte at address 0 must equal the signature for a valid image.
// RQ12 - No signature and no OTP image leaves all fields at reset defaults.
// RQ13 - Without memory, identifiers come from the built-in descriptors.
// RQ14 - Without memory, descriptor RAM and software fields supply the values.
// RQ15 - Software initialises fields, attributes, RAM, selects source, then protects.
// RQ16 - Attributes before RAM, else power and wakeup flags stay unchanged.
// RQ17 - Custom sources are used only once emulation enable is set.
// RQ18 - Software writes zero length for descriptors absent from the RAM.
// RQ19 - A 512 byte descriptor RAM is written through the data port.
// RQ20 - Attachment is allowed only after all loading has finished.
`timescale 1ns/10ps
`include "ecl_regs.vh"

module ecl_loader
(
  input wire i_clk,
  input wire i_nrst,
  input wire i_otp_configured,
  output wire o_rom_req,
  output wire [8:0] o_rom_addr,
  input wire i_rom_ack,
  input wire [31:0] i_rom_data,
  input wire i_sw_wr,
  input wire [2:0] i_sw_sel,
  input wire [31:0] i_sw_data,
  input wire i_emulation_source_enable,
  input wire i_attr_wr,
  input wire i_dram_wr,
  input wire [8:0] i_dram_addr,
  input wire [7:0] i_dram_wdata,
  input wire i_dram_cfg_attr,
  input wire [8:0] i_dram_raddr,
  output reg [7:0] o_dram_rdata,
  input wire i_compliance_mode,
  input wire [1:0] i_ltssm_deemph,
  output wire o_load_done,
  output wire o_config_present,
  output wire o_attach_enable,
  output wire o_use_builtin_desc,
  output wire o_desc_from_ram,
  output wire o_sleep_l1_suspend_enable,
  output wire o_phy_tx_swing,
  output wire [2:0] o_phy_tx_margin,
  output reg [1:0] o_phy_tx_deemph,
  output wire o_phy_elasticity_mode,
  output wire o_elasticity_cfg,
  output wire o_lfps_overlap_check_enable,
  output wire o_u2_exit_signal_select,
  output wire o_auto_duplex_polarity,
  output wire o_green_link_up_speedup,
  output wire o_green_tx_clock_stop_enable,
  output wire o_green_ethernet_enable,
  output wire o_green_lpi_auto_removal_enable,
  output wire o_duplex_select,
  output wire [1:0] o_mac_speed_cfg,
  output wire [7:0] o_u1_inactivity_timeout,
  output wire [4:0] o_resume_time_threshold,
  output wire [2:0] o_high_speed_timeout_cal,
  output wire [2:0] o_full_speed_timeout_cal,
  output wire [15:0] o_superspeed_detach_time,
  output wire [15:0] o_highspeed_detach_time,
  output wire [11:0] o_gpio_enable,
  output wire [11:0] o_gpio_buffer,
  output wire [11:0] o_gpio_dir,
  output wire [11:0] o_gpio_data,
  output reg o_power_method_flag,
  output reg o_remote_wakeup_flag
);

  localparam [3:0] S_SIG = 4'h1;
  localparam [3:0] S_LOAD = 4'h2;
  localparam [3:0] S_DONE = 4'h4;
  localparam [3:0] S_SPARE = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] idx_q;
  reg [2:0] idx_d;
  reg present_q;
  reg present_d;
  reg [8:0] addr_d;
  reg [31:0] flags1_q;
  reg [31:0] flags2_q;
  reg [31:0] flags3_q;
  reg [63:0] gpio_q;
  reg attr_seen_q;
  reg [7:0] dram_q [0:`ECL_DRAM_DEPTH-1];
  wire load_wr;
  wire sw_ok;
  wire wr_en;
  wire [2:0] wr_sel;
  wire [31:0] wr_data;

  // Walk the image: signature first, then the words
  always @*
  begin
    state_d = state_q;
    idx_d = idx_q;
    present_d = present_q;
    case (state_q)
      S_SIG:
      begin
        if (i_rom_ack)
        begin
          // see RQ11, see RQ12
          present_d = (i_rom_data[7:0] == `ECL_SIGNATURE) | i_otp_configured;
          idx_d = `ECL_IDX_FLAGS1;
          if ((i_rom_data[7:0] == `ECL_SIGNATURE) | i_otp_configured)
            state_d = S_LOAD;
          else
            state_d = S_DONE;
        end
      end
      S_LOAD:
      begin
        if (i_rom_ack)
        begin
          if (idx_q == `ECL_IDX_LAST)
            state_d = S_DONE;
          else
            idx_d = idx_q + `ECL_IDX_ONE;
        end
      end
      S_DONE:
        state_d = S_DONE;
      default:
        state_d = S_SIG;
    endcase
  end

  always @*
  begin
    case (idx_q)
      `ECL_IDX_FLAGS1: addr_d = `ECL_ADDR_FLAGS1;
      `ECL_IDX_FLAGS2: addr_d = `ECL_ADDR_FLAGS2;
      `ECL_IDX_FLAGS3: addr_d = `ECL_ADDR_FLAGS3;
      `ECL_IDX_GPIO_LO: addr_d = `ECL_ADDR_GPIO_LO;
      default: addr_d = `ECL_ADDR_GPIO_HI;
    endcase
  end

  assign o_rom_req = (state_q == S_SIG) | (state_q == S_LOAD);
  assign o_rom_addr = (state_q == S_SIG) ? `ECL_ADDR_SIG : addr_d;

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_q <= S_SIG;
      idx_q <= `ECL_IDX_FLAGS1;
      present_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      present_q <= present_d;
    end
  end

  // Image words load during the walk; software fills them only without an image
  assign load_wr = (state_q == S_LOAD) & i_rom_ack;
  assign sw_ok = (state_q == S_DONE) & ~present_q & i_sw_wr; // see RQ14
  assign wr_en = load_wr | sw_ok;
  assign wr_sel = load_wr ? idx_q : i_sw_sel;
  assign wr_data = load_wr ? i_rom_data : i_sw_data;

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      // see RQ12
      flags1_q <= `ECL_FLAGS1_RST;
      flags2_q <= `ECL_FLAGS2_RST;
      flags3_q <= `ECL_FLAGS3_RST;
      gpio_q <= `ECL_GPIO_RST;
    end
    else if (wr_en)
    begin
      case (wr_sel)
        `ECL_IDX_FLAGS1: flags1_q <= wr_data;
        `ECL_IDX_FLAGS2: flags2_q <= wr_data;
        `ECL_IDX_FLAGS3: flags3_q <= wr_data;
        `ECL_IDX_GPIO_LO: gpio_q[31:0] <= wr_data;
        `ECL_IDX_GPIO_HI: gpio_q[63:32] <= wr_data;
        default: gpio_q <= gpio_q;
      endcase
    end
  end

  assign o_load_done = (state_q == S_DONE);
  assign o_config_present = present_q;
  assign o_attach_enable = (state_q == S_DONE); // see RQ20
  assign o_use_builtin_desc = o_load_done & ~present_q & ~i_emulation_source_enable; // see RQ13
  assign o_desc_from_ram = o_load_done & ~present_q & i_emulation_source_enable; // see RQ17

  assign o_sleep_l1_suspend_enable = flags1_q[`ECL_F1_SLEEP]; // see RQ1
  assign o_phy_tx_swing = flags1_q[`ECL_F1_SWING]; // see RQ2
  assign o_phy_tx_margin = flags1_q[`ECL_F1_MARGIN]; // see RQ2
  assign o_elasticity_cfg = flags1_q[`ECL_F1_ELASTIC]; // see RQ2
  assign o_phy_elasticity_mode = 1'b0; // see RQ4

  // Compliance hands de-emphasis to the link state machine
  always @*
  begin
    if (i_compliance_mode)
      o_phy_tx_deemph = i_ltssm_deemph; // see RQ3
    else
      o_phy_tx_deemph = flags1_q[`ECL_F1_DEEMPH]; // see RQ2
  end

  assign o_lfps_overlap_check_enable = flags2_q[`ECL_F2_OVERLAP]; // see RQ5
  assign o_u2_exit_signal_select = flags2_q[`ECL_F2_U2_EXIT]; // see RQ5
  assign o_green_tx_clock_stop_enable = flags2_q[`ECL_F2_CLK_STOP]; // see RQ6
  assign o_green_ethernet_enable = flags2_q[`ECL_F2_GREEN_EN]; // see RQ6
  assign o_green_lpi_auto_removal_enable = flags2_q[`ECL_F2_LPI_REM]; // see RQ6
  assign o_green_link_up_speedup = flags2_q[`ECL_F2_SPEEDUP]; // see RQ7
  assign o_auto_duplex_polarity = flags2_q[`ECL_F2_ADP]; // see RQ7
  assign o_duplex_select = flags2_q[`ECL_F2_DUPLEX]; // see RQ7
  assign o_mac_speed_cfg = flags2_q[`ECL_F2_SPEED]; // see RQ7
  assign o_u1_inactivity_timeout = flags2_q[`ECL_F2_U1_INACTIVITY_TIMEOUT]; // see RQ8
  assign o_resume_time_threshold = flags2_q[`ECL_F2_RESUME]; // see RQ8
  assign o_high_speed_timeout_cal = flags2_q[`ECL_F2_HS_CAL]; // see RQ8
  assign o_full_speed_timeout_cal = flags2_q[`ECL_F2_FS_CAL]; // see RQ8
  assign o_superspeed_detach_time = flags3_q[`ECL_F3_SS_DETACH]; // see RQ9
  assign o_highspeed_detach_time = flags3_q[`ECL_F3_HIGHSPEED_DETACH_TIME]; // see RQ9
  assign o_gpio_enable = gpio_q[`ECL_G_ENABLE]; // see RQ10
  assign o_gpio_buffer = gpio_q[`ECL_G_BUFFER]; // see RQ10
  assign o_gpio_dir = gpio_q[`ECL_G_DIR]; // see RQ10
  assign o_gpio_data = gpio_q[`ECL_G_DATA]; // see RQ10

  // Descriptor RAM data port
  always @(posedge i_clk)
  begin
    if (i_dram_wr)
      dram_q[i_dram_addr] <= i_dram_wdata; // see RQ19
    o_dram_rdata <= dram_q[i_dram_raddr];
  end

  // Attribute byte updates the flags only after attributes were written
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      attr_seen_q <= 1'b0;
      o_power_method_flag <= `ECL_PWR_RST;
      o_remote_wakeup_flag <= `ECL_RWAKE_RST;
    end
    else
    begin
      if (i_attr_wr)
        attr_seen_q <= 1'b1;
      if (i_dram_wr & i_dram_cfg_attr & attr_seen_q)
      begin
        o_power_method_flag <= i_dram_wdata[`ECL_ATTR_SELF_PWR]; // see RQ16
        o_remote_wakeup_flag <= i_dram_wdata[`ECL_ATTR_RWAKE]; // see RQ16
      end
    end
  end

endmodule

// *** core/ecl_regs.vh ***
`ifndef ECL_REGS_VH
`define ECL_REGS_VH

// Image byte addresses of the configuration memory
`define ECL_ADDR_SIG 9'h000
`define ECL_ADDR_FLAGS1 9'h008
`define ECL_ADDR_FLAGS2 9'h00c
`define ECL_ADDR_FLAGS3 9'h010
`define ECL_ADDR_GPIO_LO 9'h014
`define ECL_ADDR_GPIO_HI 9'h018
`define ECL_SIGNATURE 8'ha5

// Reset defaults of the loadable words
`define ECL_FLAGS1_RST 32'h0000_0000
`define ECL_FLAGS2_RST 32'h0000_0000
`define ECL_FLAGS3_RST 32'h0000_0000
`define ECL_GPIO_RST 64'h0000_0000_0000_0000

// Word index of the load sequence and software select
`define ECL_IDX_FLAGS1 3'h0
`define ECL_IDX_FLAGS2 3'h1
`define ECL_IDX_FLAGS3 3'h2
`define ECL_IDX_GPIO_LO 3'h3
`define ECL_IDX_GPIO_HI 3'h4
`define ECL_IDX_LAST 3'h4
`define ECL_IDX_ONE 3'h1

// Flags word 1 fields
`define ECL_F1_SLEEP 7
`define ECL_F1_SWING 6
`define ECL_F1_MARGIN 5:3
`define ECL_F1_DEEMPH 2:1
`define ECL_F1_ELASTIC 0

// Flags word 2 fields
`define ECL_F2_U1_INACTIVITY_TIMEOUT 31:24
`define ECL_F2_RESUME 20:16
`define ECL_F2_OVERLAP 15
`define ECL_F2_U2_EXIT 14
`define ECL_F2_ADP 13
`define ECL_F2_SPEEDUP 12
`define ECL_F2_CLK_STOP 11
`define ECL_F2_GREEN_EN 10
`define ECL_F2_LPI_REM 9
`define ECL_F2_DUPLEX 8
`define ECL_F2_SPEED 7:6
`define ECL_F2_HS_CAL 5:3
`define ECL_F2_FS_CAL 2:0

// Flags word 3 fields
`define ECL_F3_SS_DETACH 31:16
`define ECL_F3_HIGHSPEED_DETACH_TIME 15:0

// GPIO configuration fields
`define ECL_G_ENABLE 59:48
`define ECL_G_BUFFER 43:32
`define ECL_G_DIR 27:16
`define ECL_G_DATA 11:0

// Descriptor RAM and attribute byte bits
`define ECL_DRAM_DEPTH 512
`define ECL_ATTR_SELF_PWR 6
`define ECL_ATTR_RWAKE 5
`define ECL_PWR_RST 1'b0
`define ECL_RWAKE_RST 1'b0

`endif

// *** tb/ecl_chk_asserts.sv ***
`timescale 1ns/10ps
module ecl_chk (
  input wire i_clk,
  input wire i_nrst,
  input wire i_otp_configured,
  input wire o_rom_req,
  input wire [8:0] o_rom_addr,
  input wire i_rom_ack,
  input wire [31:0] i_rom_data,
  input wire i_compliance_mode,
  input wire [1:0] i_ltssm_deemph,
  input wire o_load_done,
  input wire o_config_present,
  input wire o_attach_enable,
  input wire [1:0] o_phy_tx_deemph,
  input wire o_phy_elasticity_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_sig_ok;
    o_rom_req && o_rom_addr == 9'h000 && i_rom_ack && i_rom_data[7:0] == 8'ha5;
  endsequence
  sequence s_sig_bad;
    o_rom_req && o_rom_addr == 9'h000 && i_rom_ack && i_rom_data[7:0] != 8'ha5 && !i_otp_configured;
  endsequence
  sequence s_sig_otp;
    o_rom_req && o_rom_addr == 9'h000 && i_rom_ack && i_otp_configured;
  endsequence
  sequence s_last_ack;
    o_rom_req && o_rom_addr == 9'h018 && i_rom_ack;
  endsequence
  a_first_req: assert property (!$past(i_nrst) |-> o_rom_req && o_rom_addr == 9'h000) else $error("bad first read");
  a_good_sig: assert property (s_sig_ok |=> o_rom_req && o_rom_addr == 9'h008) else $error("no load");
  a_bad_sig: assert property (s_sig_bad |=> o_load_done && !o_rom_req && !o_config_present) else $error("bad");
  a_otp_load: assert property (s_sig_otp |=> o_rom_req && o_rom_addr == 9'h008 && o_config_present) else $error("otp load");
  a_attach_rise: assert property ($rose(o_attach_enable) |-> $past(i_rom_ack) && !o_rom_req) else $error("attach early");
  a_load_end: assert property (s_last_ack |=> o_load_done && !o_rom_req ##1 o_load_done) else $error("end");
  a_req_hold: assert property (o_rom_req && !i_rom_ack |=> o_rom_req && $stable(o_rom_addr)) else $error("hold");
  a_attach_done: assert property (o_attach_enable == o_load_done && !(o_load_done && o_rom_req)) else $error("att");
  a_done_holds: assert property (o_load_done |=> o_load_done) else $error("done dropped");
  a_deemph_ltssm: assert property (i_compliance_mode |-> o_phy_tx_deemph == i_ltssm_deemph) else $error("de");
  a_elastic_off: assert property (o_phy_elasticity_mode == 1'b0) else $error("elastic");
endmodule

// *** tb/ecl_rom_model.sv ***
`timescale 1ns/10ps
module ecl_rom_model (
  input wire i_clk,
  input wire i_req,
  input wire [8:0] i_addr,
  input wire [3:0] i_wait,
  output reg o_ack,
  output reg [31:0] o_data
);
  reg [31:0] mem [0:7]; // Word 0 holds the signature byte
  reg [3:0] cnt_q = 4'h0;
  initial
  begin
    o_ack = 1'b0;
    o_data = 32'h0;
  end
  // Answers after i_wait cycles; data toggles while not valid
  always @(posedge i_clk)
  begin
    o_ack <= 1'b0;
    o_data <= ~o_data;
    cnt_q <= 4'h0;
    if (i_req && !o_ack && cnt_q == i_wait)
    begin
      o_ack <= 1'b1;
      o_data <= mem[i_addr[4:2]];
    end
    else if (i_req && !o_ack)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam [31:0] W1 = 32'h0000_00b5;
  localparam [31:0] W2 = 32'h9a1f_aaed;
  localparam [31:0] W3 = 32'h1234_abcd;
  localparam [63:0] G = 64'h0b2d_0e71_0a5c_0c3f;
  reg i_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg i_otp_configured = 1'b0;
  reg i_sw_wr = 1'b0;
  reg [2:0] i_sw_sel = 3'h0;
  reg [31:0] i_sw_data = 32'h0;
  reg i_emulation_source_enable = 1'b0;
  reg i_attr_wr = 1'b0;
  reg i_dram_wr = 1'b0;
  reg [8:0] i_dram_addr = 9'h0;
  reg [7:0] i_dram_wdata = 8'h0;
  reg i_dram_cfg_attr = 1'b0;
  reg [8:0] i_dram_raddr = 9'h0;
  reg i_compliance_mode = 1'b0;
  reg [1:0] i_ltssm_deemph = 2'h0;
  reg [3:0] rom_wait = 4'h0;
  integer fails = 0;
  integer check_count = 0;
  wire o_rom_req, i_rom_ack, o_load_done, o_config_present, o_attach_enable, o_use_builtin_desc, o_desc_from_ram;
  wire o_sleep_l1_suspend_enable, o_phy_tx_swing, o_phy_elasticity_mode, o_elasticity_cfg;
  wire o_lfps_overlap_check_enable, o_u2_exit_signal_select, o_auto_duplex_polarity, o_green_link_up_speedup;
  wire o_green_tx_clock_stop_enable, o_green_ethernet_enable, o_green_lpi_auto_removal_enable, o_duplex_select;
  wire o_power_method_flag, o_remote_wakeup_flag;
  wire [1:0] o_phy_tx_deemph, o_mac_speed_cfg;
  wire [2:0] o_phy_tx_margin, o_high_speed_timeout_cal, o_full_speed_timeout_cal;
  wire [4:0] o_resume_time_threshold;
  wire [7:0] o_u1_inactivity_timeout, o_dram_rdata;
  wire [8:0] o_rom_addr;
  wire [15:0] o_superspeed_detach_time, o_highspeed_detach_time;
  wire [11:0] o_gpio_enable, o_gpio_buffer, o_gpio_dir, o_gpio_data;
  wire [31:0] i_rom_data;
  ecl_loader u_dut (.*);
  ecl_rom_model u_rom (.i_clk(i_clk), .i_req(o_rom_req), .i_addr(o_rom_addr), .i_wait(rom_wait),
    .o_ack(i_rom_ack), .o_data(i_rom_data));
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [63:0] seen, input [63:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task rst_wait;
    integer n;
  begin
    i_nrst = 1'b0;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    for (n = 0; n < 200 && o_load_done !== 1'b1; n = n + 1)
      @(negedge i_clk);
    if (o_load_done !== 1'b1)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  endtask
  task sw(input [2:0] sel, input [31:0] d);
  begin
    i_sw_wr = 1'b1;
    i_sw_sel = sel;
    i_sw_data = d;
    @(negedge i_clk);
    i_sw_wr = 1'b0;
    @(negedge i_clk);
  end
  endtask
  task dram(input [8:0] a, input [7:0] d, input cfg);
  begin
    i_dram_wr = 1'b1;
    i_dram_addr = a;
    i_dram_wdata = d;
    i_dram_cfg_attr = cfg;
    @(negedge i_clk);
    i_dram_wr = 1'b0;
    i_dram_cfg_attr = 1'b0;
    @(negedge i_clk);
  end
  endtask
  task chk_fields(input [31:0] w1, input [31:0] w2, input [31:0] w3, input [63:0] g);
  begin
    chk(o_sleep_l1_suspend_enable, w1[7]);
    chk({o_phy_tx_swing, o_phy_tx_margin, o_phy_tx_deemph}, w1[6:1]);
    chk({o_elasticity_cfg, o_phy_elasticity_mode}, {w1[0], 1'b0});
    chk({o_lfps_overlap_check_enable, o_u2_exit_signal_select}, w2[15:14]);
    chk({o_green_tx_clock_stop_enable, o_green_ethernet_enable, o_green_lpi_auto_removal_enable}, w2[11:9]);
    chk({o_auto_duplex_polarity, o_green_link_up_speedup, o_duplex_select, o_mac_speed_cfg}, {w2[13:12], w2[8:6]});
    chk({o_u1_inactivity_timeout, o_resume_time_threshold, o_high_speed_timeout_cal, o_full_speed_timeout_cal},
      {w2[31:24], w2[20:16], w2[5:0]});
    chk({o_superspeed_detach_time, o_highspeed_detach_time}, w3);
    chk({o_gpio_enable, o_gpio_buffer, o_gpio_dir, o_gpio_data}, {g[59:48], g[43:32], g[27:16], g[11:0]});
  end
  endtask
  task t_load(input [3:0] dly, input [7:0] sig, input otp);
  begin
    rom_wait = dly;
    i_otp_configured = otp;
    u_rom.mem[0] = {24'h0, sig};
    rst_wait;
    sw(3'h0, 32'h0);
    chk({o_config_present, o_attach_enable, o_use_builtin_desc}, 3'h6);
    chk_fields(W1, W2, W3, G);
    i_compliance_mode = 1'b1;
    i_ltssm_deemph = 2'h1;
    @(negedge i_clk);
    chk(o_phy_tx_deemph, 2'h1);
    i_compliance_mode = 1'b0;
    $display("test load done");
  end
  endtask
  task t_none;
    integer i;
  begin
    i_otp_configured = 1'b0;
    u_rom.mem[0] = 32'h0000_005a;
    rst_wait;
    chk({o_config_present, o_use_builtin_desc, o_desc_from_ram}, 3'h2);
    chk_fields(32'h0, 32'h0, 32'h0, 64'h0);
    // Driver order: fields, attribute byte before attributes, attributes, RAM, then source select
    for (i = 0; i < 5; i = i + 1)
      sw(i[2:0], ~u_rom.mem[i + 2]);
    sw(3'h5, 32'h0);
    @(negedge i_clk);
    chk_fields(~W1, ~W2, ~W3, ~G);
    dram(9'h004, 8'h60, 1'b1);
    chk({o_power_method_flag, o_remote_wakeup_flag}, 2'h0);
    i_attr_wr = 1'b1;
    @(negedge i_clk);
    i_attr_wr = 1'b0;
    dram(9'h004, 8'h60, 1'b1);
    dram(9'h1ff, 8'h3c, 1'b0);
    i_dram_raddr = 9'h1ff;
    i_emulation_source_enable = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({o_power_method_flag, o_remote_wakeup_flag}, 2'h3);
    chk(o_dram_rdata, 8'h3c);
    chk({o_use_builtin_desc, o_desc_from_ram}, 2'h1);
    $display("test no memory done");
  end
  endtask
  initial
  begin
    u_rom.mem[2] = W1;
    u_rom.mem[3] = W2;
    u_rom.mem[4] = W3;
    u_rom.mem[5] = G[31:0];
    u_rom.mem[6] = G[63:32];
    t_load(4'h0, 8'ha5, 1'b0);
    t_load(4'h3, 8'h5a, 1'b1);
    t_none;
    tally_and_finish;
  end
endmodule
bind ecl_loader ecl_chk u_chk (.*);
